/* File: src/psp_div.sv */
// Sequential restoring divider shared by the stage arithmetic.
`timescale 1ns/1ps
module psp_div #(
  parameter int W = 48
) (
  // Clock, reset, enable
  input  wire logic         i_sys_clk,
  input  wire logic         i_srst,
  input  wire logic         i_ce,
  // Request
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_num,
  input  wire logic [W-1:0] i_den,
  // Answer
  output logic              o_done,
  output logic [W-1:0]      o_quot
);

  localparam int CW = $clog2(W + 1);

  initial begin
    if (W < 8) begin
      $error("psp_div: W too small");
    end
  end

  logic [W:0]    rem;
  logic [W-1:0]  quo;
  logic [CW-1:0] cnt;
  logic          busy;

  // Zero divisor yields all ones, read later as an endless delay
  wire [W:0] trial    = {rem[W-1:0], quo[W-1]};
  wire       fits     = trial >= {1'b0, i_den};
  wire [W:0] next_rem = fits ? trial - {1'b0, i_den} : trial;

  assign o_quot = quo;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rem    <= '0;
      quo    <= '0;
      cnt    <= '0;
      busy   <= 1'b0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      if (i_start) begin
        rem  <= '0;
        quo  <= i_num;
        cnt  <= CW'(W);
        busy <= 1'b1;
      end else if (busy) begin
        rem <= next_rem;
        quo <= {quo[W-2:0], fits};
        cnt <= cnt - 1'b1;
        if (cnt == CW'(1)) begin
          busy   <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end

endmodule // psp_div

/* File: src/psp_pkg.sv */
// Constants, register map and state encoding of the protection stage.
package psp_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TICK_PERIOD_US  = 1000;
  localparam int TICK_CYCLES_DEF =
    (TICK_PERIOD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // One evaluation takes about 150 cycles of division work
  localparam int MIN_TICK_CYCLES = 256;
  localparam int DIV_W           = 48;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_PICKUP   = 8'h04;
  localparam logic [7:0] ADDR_DELAY    = 8'h08;
  localparam logic [7:0] ADDR_TMS      = 8'h0c;
  localparam logic [7:0] ADDR_CONST_A  = 8'h10;
  localparam logic [7:0] ADDR_CONST_B  = 8'h14;
  localparam logic [7:0] ADDR_CONST_C  = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1c;
  localparam logic [7:0] ADDR_RATIO    = 8'h20;
  localparam logic [7:0] ADDR_EVT_TIME = 8'h24;
  localparam logic [7:0] ADDR_EVT_MEAS = 8'h28;

  // ****************************************************************
  // Fields and values after reset
  // ****************************************************************
  localparam int CTRL_DIR_BIT  = 0;
  localparam int CTRL_INV_BIT  = 1;
  localparam int CTRL_IEEE_BIT = 2;
  localparam logic [2:0]  CTRL_RST     = 3'h0;
  localparam logic [15:0] PICKUP_RST   = 16'h0100;
  localparam logic [20:0] DELAY_RST    = 21'h0_0000;
  localparam logic [20:0] DELAY_MAX_MS = 21'h1b_7740;
  localparam logic [15:0] TMS_RST      = 16'h0005;
  localparam logic [15:0] TMS_MIN      = 16'h0001;
  localparam logic [15:0] TMS_MAX      = 16'h09c4;
  localparam logic [21:0] CONST_A_RST  = 22'h00_035c;
  localparam logic [21:0] CONST_B_RST  = 22'h00_073a;
  localparam logic [21:0] CONST_C_RST  = 22'h00_00c8;
  localparam logic [21:0] CONST_MAX    = 22'h26_25a0;

  // ****************************************************************
  // Arithmetic constants
  // ****************************************************************
  localparam logic [6:0]  RESET_PCT   = 7'h61;
  localparam logic [6:0]  FULL_PCT    = 7'h64;
  localparam logic [15:0] Q8_ONE      = 16'h0100;
  localparam int          Q8_SHIFT    = 8;
  localparam logic [13:0] CONST_SCALE = 14'h2710;
  localparam logic [9:0]  MS_SCALE    = 10'h3e8;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SAMPLE = 3'b001,
    ST_RATIO  = 3'b011,
    ST_INV    = 3'b010,
    ST_SCALE  = 3'b110,
    ST_EVAL   = 3'b111
  } psp_state_e;

endpackage

/* File: src/psp_stage.sv */
// Protection stage: pick-up, blocking, trip timing and AHB-Lite registers.
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps

// Summary of operation
// - Pick-up level is maximum or minimum allowed
// - Ratio of setting and measurement every tick
// - Release at 97 percent of pick-up setting (over); under mode releases at 100/97 of it
// - Sample blocking input at cycle start
// - Unblocked pick-up asserts start, starts timing
// - Stage_inhibited_flag pick-up asserts inhibited flag only
// - Blocking clears start, timer resets as release
// - Blocking emits stamped event with values, type
// - Instant operation trips with start
// - Fixed delay trips after set delay
// - Inverse delay from ratio and curve constants
// - Fixed delay floors inverse time; zero disables
// - Delay range accepted; zero means instant in fixed mode
// - Selector picks inverse or fixed delay
// - Series selector IEC or IEEE, inverse only
// - Multiplier in 0.01 s steps, default 0.05
// - IEEE delay k*(A/(r^C-1)+B), C 0.0200
module psp_stage
  import psp_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int MEAS_W      = 16
) (
  // Clock, reset, enable
  input  wire logic              i_sys_clk,
  input  wire logic              i_srst,
  input  wire logic              i_ce,
  // AHB-Lite slave
  input  wire logic              i_hsel,
  input  wire logic [31:0]       i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic      [31:0]       o_hrdata,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  // Measurement and blocking
  input  wire logic [MEAS_W-1:0] i_meas,
  input  wire logic              i_block_pin,
  // Stage outputs
  output logic                   o_start,
  output logic                   o_trip,
  output logic                   o_stage_inhibited_flag,
  // Blocking event
  output logic                   o_evt_valid,
  output logic      [31:0]       o_evt_time,
  output logic      [MEAS_W-1:0] o_evt_meas,
  output logic                   o_evt_fault
);

  localparam int TCW = $clog2(TICK_CYCLES + 1);

  initial begin
    if (TICK_CYCLES < MIN_TICK_CYCLES) begin
      $error("psp_stage: TICK_CYCLES too small for one evaluation");
    end
    if (MEAS_W < 8 || MEAS_W > 16) begin
      $error("psp_stage: MEAS_W must be 8 to 16");
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] sat16(input logic [DIV_W-1:0] v);
    sat16 = (v > DIV_W'(16'hffff)) ? 16'hffff : v[15:0];
  endfunction

  function automatic logic [31:0] sat32(input logic [63:0] v);
    sat32 = (v > 64'h0000_0000_ffff_ffff) ? 32'hffff_ffff : v[31:0];
  endfunction

  function automatic logic [DIV_W-1:0] sat48(input logic [63:0] v);
    sat48 = (v > 64'(DIV_W'('1))) ? DIV_W'('1) : v[DIV_W-1:0];
  endfunction

  function automatic logic [21:0] clamp_const(input logic [31:0] v);
    clamp_const = (v > 32'(CONST_MAX)) ? CONST_MAX : v[21:0];
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [2:0]        ctrl;
  logic [15:0]       pickup;
  logic [20:0]       delay;
  logic [15:0]       tms;
  logic [21:0]       const_a;
  logic [21:0]       const_b;
  logic [21:0]       const_c;
  logic [15:0]       ratio;
  logic              wr_pend;
  logic [7:0]        wr_addr;

  logic              pu;
  logic              start;
  logic              trip;
  logic              inhibited;
  logic [31:0]       elapsed;
  logic [31:0]       inv_ticks;
  logic [31:0]       stamp;
  logic [MEAS_W-1:0] meas_s;
  logic              blk_s;
  logic              blk_meta;
  logic              blk_sync;
  logic [TCW-1:0]    tick_cnt;
  psp_state_e        state;

  logic              div_start;
  logic [DIV_W-1:0]  div_num;
  logic [DIV_W-1:0]  div_den;
  logic              div_done;
  logic [DIV_W-1:0]  div_quot;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire addr_ok = i_hsel & i_htrans[1] & i_hready;
  wire [7:0]  ra = i_haddr[7:0];
  wire [31:0] status_word = {28'h000_0000, inhibited, trip, start, pu};
  wire [31:0] rd_word =
    (ra == ADDR_CTRL)     ? {29'h0000_0000, ctrl}        :
    (ra == ADDR_PICKUP)   ? {16'h0000, pickup}           :
    (ra == ADDR_DELAY)    ? {11'h000, delay}             :
    (ra == ADDR_TMS)      ? {16'h0000, tms}              :
    (ra == ADDR_CONST_A)  ? {10'h000, const_a}           :
    (ra == ADDR_CONST_B)  ? {10'h000, const_b}           :
    (ra == ADDR_CONST_C)  ? {10'h000, const_c}           :
    (ra == ADDR_STATUS)   ? status_word                  :
    (ra == ADDR_RATIO)    ? {16'h0000, ratio}            :
    (ra == ADDR_EVT_TIME) ? o_evt_time                   :
    (ra == ADDR_EVT_MEAS) ? 32'(o_evt_meas)              :
    32'h0000_0000;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      wr_pend     <= 1'b0;
      wr_addr     <= 8'h00;
    end else if (i_ce) begin
      wr_pend <= addr_ok & i_hwrite;
      wr_addr <= ra;
      if (addr_ok & ~i_hwrite) begin
        o_hrdata <= rd_word;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      ctrl    <= CTRL_RST;
      pickup  <= PICKUP_RST;
      delay   <= DELAY_RST;
      tms     <= TMS_RST;
      const_a <= CONST_A_RST;
      const_b <= CONST_B_RST;
      const_c <= CONST_C_RST;
    end else if (i_ce && wr_pend) begin
      case (wr_addr)
        ADDR_CTRL:    ctrl   <= i_hwdata[2:0];
        ADDR_PICKUP:  pickup <= i_hwdata[15:0];
        ADDR_DELAY: begin
          delay <= (i_hwdata > 32'(DELAY_MAX_MS)) ? DELAY_MAX_MS
                                                  : i_hwdata[20:0];
        end
        ADDR_TMS: begin
          tms <= (i_hwdata > 32'(TMS_MAX)) ? TMS_MAX :
                 (i_hwdata < 32'(TMS_MIN)) ? TMS_MIN : i_hwdata[15:0];
        end
        ADDR_CONST_A: const_a <= clamp_const(i_hwdata);
        ADDR_CONST_B: const_b <= clamp_const(i_hwdata);
        ADDR_CONST_C: const_c <= clamp_const(i_hwdata);
        default:      ctrl    <= ctrl;
      endcase
    end
  end

  // ****************************************************************
  // Evaluation tick and blocking synchroniser
  // ****************************************************************
  wire tick_hit = tick_cnt == TCW'(TICK_CYCLES - 1);

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      tick_cnt <= '0;
      stamp    <= 32'h0000_0000;
      blk_meta <= 1'b0;
      blk_sync <= 1'b0;
    end else if (i_ce) begin
      tick_cnt <= tick_hit ? '0 : tick_cnt + 1'b1;
      stamp    <= tick_hit ? stamp + 32'h0000_0001 : stamp;
      blk_meta <= i_block_pin;
      blk_sync <= blk_meta;
    end
  end

  // ****************************************************************
  // Arithmetic datapath
  // ****************************************************************
  wire over   = ~ctrl[CTRL_DIR_BIT];
  wire inv_on = ctrl[CTRL_INV_BIT];
  wire ieee   = ctrl[CTRL_IEEE_BIT];

  // Ratio in Q8, oriented so that a fault is always above one
  wire [DIV_W-1:0] ratio_num = over ? (DIV_W'(i_meas) << Q8_SHIFT)
                                    : (DIV_W'(pickup) << Q8_SHIFT);
  wire [DIV_W-1:0] ratio_den = over ? DIV_W'(pickup) : DIV_W'(i_meas);
  wire [15:0]      ratio_q   = sat16(div_quot);
  wire [15:0]      excess    = (ratio_q > Q8_ONE) ? ratio_q - Q8_ONE
                                                  : 16'h0000;
  // r^C - 1 taken as C*(r-1): fair near pick-up, pessimistic far above
  wire [DIV_W-1:0] inv_num = ieee
    ? DIV_W'(const_a) * DIV_W'(Q8_ONE) * DIV_W'(CONST_SCALE)
    : DIV_W'(const_a) * DIV_W'(Q8_ONE);
  wire [DIV_W-1:0] inv_den = ieee ? DIV_W'(excess) * DIV_W'(const_c)
                                  : DIV_W'(excess);
  wire [DIV_W:0]   sum_b   = {1'b0, div_quot} + (DIV_W+1)'(const_b);
  wire [DIV_W-1:0] inv_sum = ieee ? sat48(64'(sum_b))
                                  : div_quot;
  wire [DIV_W-1:0] scale_num = sat48(64'(inv_sum) * 64'(tms));

  // ****************************************************************
  // Pick-up, blocking and trip decision
  // ****************************************************************
  wire [23:0] meas_full  = 24'(meas_s) * 24'(FULL_PCT);
  wire [23:0] meas_rst   = 24'(meas_s) * 24'(RESET_PCT);
  wire [23:0] set_full   = 24'(pickup) * 24'(FULL_PCT);
  wire [23:0] set_rst    = 24'(pickup) * 24'(RESET_PCT);
  wire [15:0] meas_w     = 16'(meas_s);
  wire next_pu = over
    ? (pu ? meas_full >= set_rst : meas_w > pickup)
    : (pu ? meas_rst <= set_full : meas_w < pickup);
  wire next_inhibited = next_pu & blk_s;
  wire active         = next_pu & ~blk_s;
  wire [31:0] next_elapsed = (active & start)
    ? sat32(64'(elapsed) + 64'h1) : 32'h0000_0000;
  wire [31:0] floor_ticks = 32'(delay);
  wire [31:0] target = inv_on
    ? ((inv_ticks > floor_ticks) ? inv_ticks : floor_ticks)
    : floor_ticks;
  // Hold trip once reached; drops with start
  wire next_trip = active & (trip | (next_elapsed >= target));

  // ****************************************************************
  // Sequencer, one pass per tick
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state       <= ST_IDLE;
      div_start   <= 1'b0;
      div_num     <= '0;
      div_den     <= '0;
      ratio       <= 16'h0000;
      inv_ticks   <= 32'hffff_ffff;
      meas_s      <= '0;
      blk_s       <= 1'b0;
      pu          <= 1'b0;
      start       <= 1'b0;
      trip        <= 1'b0;
      inhibited   <= 1'b0;
      elapsed     <= 32'h0000_0000;
      o_evt_valid <= 1'b0;
      o_evt_time  <= 32'h0000_0000;
      o_evt_meas  <= '0;
      o_evt_fault <= 1'b0;
    end else if (i_ce) begin
      div_start   <= 1'b0;
      o_evt_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (tick_hit) begin
            state <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          blk_s     <= blk_sync;
          meas_s    <= i_meas;
          div_num   <= ratio_num;
          div_den   <= ratio_den;
          div_start <= 1'b1;
          state     <= ST_RATIO;
        end
        ST_RATIO: begin
          if (div_done) begin
            ratio     <= ratio_q;
            div_num   <= inv_num;
            div_den   <= inv_den;
            div_start <= 1'b1;
            state     <= ST_INV;
          end
        end
        ST_INV: begin
          if (div_done) begin
            div_num   <= scale_num;
            div_den   <= DIV_W'(MS_SCALE);
            div_start <= 1'b1;
            state     <= ST_SCALE;
          end
        end
        ST_SCALE: begin
          if (div_done) begin
            inv_ticks <= sat32(64'(div_quot));
            state     <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          pu        <= next_pu;
          start     <= active;
          trip      <= next_trip;
          inhibited <= next_inhibited;
          elapsed   <= next_elapsed;
          if (next_inhibited & ~inhibited) begin
            o_evt_valid <= 1'b1;
            o_evt_time  <= stamp;
            o_evt_meas  <= meas_s;
            o_evt_fault <= ~over;
          end
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign o_start                = start;
  assign o_trip                 = trip;
  assign o_stage_inhibited_flag = inhibited;

  // ****************************************************************
  // Divider
  // ****************************************************************
  psp_div #(
    .W (DIV_W)
  ) u_div (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_ce      (i_ce),
    .i_start   (div_start),
    .i_num     (div_num),
    .i_den     (div_den),
    .o_done    (div_done),
    .o_quot    (div_quot)
  );

endmodule // psp_stage

/* File: testbench/psp_chk.sv */
// Assertion checker for the protection stage outputs.
`timescale 1ns/1ps
module psp_chk #(
  parameter int TICK_CYCLES = 100000
) (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_srst,
  // Watched signals
  input  wire logic i_block_pin,
  input  wire logic o_start,
  input  wire logic o_trip,
  input  wire logic o_stage_inhibited_flag,
  input  wire logic o_evt_valid
);
  // ****
  // Blocking hold counter
  // ****
  // Two ticks of steady blocking always cover one full sample
  // Wide enough for two ticks at the full tick length
  logic [31:0] blk_cnt;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !i_block_pin) begin
      blk_cnt <= 32'h0000_0000;
    end else if (blk_cnt != 32'hffff_ffff) begin
      blk_cnt <= blk_cnt + 32'h0000_0001;
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  a_trip_with_start: assert property (o_trip |-> o_start)
    else $error("trip without start");
  a_start_excl: assert property (!(o_start && o_stage_inhibited_flag))
    else $error("start while inhibited");
  a_evt_on_flag: assert property (
    o_evt_valid |-> o_stage_inhibited_flag)
    else $error("event without inhibit");
  a_evt_pulse: assert property (o_evt_valid |=> !o_evt_valid)
    else $error("event longer than one cycle");
  a_evt_cause: assert property (
    $rose(o_stage_inhibited_flag) |-> ##[0:1] o_evt_valid)
    else $error("inhibit without event");
  a_drop_together: assert property ($fell(o_trip) |-> $fell(o_start))
    else $error("trip fell apart from start");
  a_start_hold: assert property ($rose(o_start) |=> o_start [*8])
    else $error("start changed within a tick");
  a_block_holds: assert property (
    (blk_cnt >= 32'(2 * TICK_CYCLES)) |-> !o_start && !o_trip)
    else $error("start during steady blocking");
endmodule // psp_chk

bind psp_stage psp_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .i_sys_clk              (i_sys_clk),
  .i_srst                 (i_srst),
  .i_block_pin            (i_block_pin),
  .o_start                (o_start),
  .o_trip                 (o_trip),
  .o_stage_inhibited_flag (o_stage_inhibited_flag),
  .o_evt_valid            (o_evt_valid)
);

/* File: testbench/psp_front_model.sv */
// Model of the measurement front end and the blocking matrix.
`timescale 1ns/1ps
module psp_front_model (
  // Clock
  input  wire logic        i_sys_clk,
  // Requested values
  input  wire logic [15:0] i_level,
  input  wire logic        i_block_req,
  // To the stage
  output logic      [15:0] o_meas,
  output logic             o_block
);
  // Requests are raised ticks ahead of any delay running out
  always @(posedge i_sys_clk) begin
    o_meas <= i_level;
    o_block <= i_block_req;
  end
endmodule // psp_front_model

/* File: testbench/tb.sv */
// Self-checking testbench of the protection stage.
`timescale 1ns/1ps
module tb;
  import psp_pkg::*;
  localparam int TICK = 300;
  logic        i_sys_clk = 1'b0;
  logic        i_srst    = 1'b1;
  logic        hsel      = 1'b0;
  logic        hwrite    = 1'b0;
  logic [1:0]  htrans    = 2'h0;
  logic [31:0] haddr     = 32'h0000_0000;
  logic [31:0] hwdata    = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hready, hresp;
  logic [15:0] lvl       = 16'h0000;
  logic [15:0] meas, evt_m;
  logic        blk_req   = 1'b0;
  logic        blk, start, trip, flag, evt_v, evt_f;
  logic [31:0] evt_t;
  int          bad_count = 0;
  int          n_tests   = 0;
  int          cyc       = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  // Cycles since reset release, for the event stamp
  always @(posedge i_sys_clk) begin
    if (!i_srst) begin
      cyc <= cyc + 1;
    end
  end

  psp_front_model i_front (.i_sys_clk(i_sys_clk), .i_level(lvl),
    .i_block_req(blk_req), .o_meas(meas), .o_block(blk));

  psp_stage #(.TICK_CYCLES(TICK)) i_dut (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(1'b1),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .i_meas(meas), .i_block_pin(blk),
    .o_start(start), .o_trip(trip), .o_stage_inhibited_flag(flag),
    .o_evt_valid(evt_v), .o_evt_time(evt_t), .o_evt_meas(evt_m),
    .o_evt_fault(evt_f));

  // ****
  // Helpers
  // ****
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do @(posedge i_sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge i_sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0000_0000, x);
    check(n, x, e);
  endtask

  // Waits on start (or trip) at falling edges, bounded
  task automatic wait_out(input bit sel_trip, input logic v, output int n);
    n = 0;
    while (((sel_trip ? trip : start) !== v) && n < 20 * TICK) begin
      @(negedge i_sys_clk);
      n++;
    end
    check("output level", sel_trip ? trip : start, 32'(v));
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    logic [7:0]  a [8];
    logic [31:0] e [8];
    a = '{ADDR_CTRL, ADDR_PICKUP, ADDR_DELAY, ADDR_TMS, ADDR_CONST_A,
          ADDR_CONST_B, ADDR_CONST_C, 8'h40};
    e = '{32'(CTRL_RST), 32'(PICKUP_RST), 32'(DELAY_RST), 32'(TMS_RST),
          32'(CONST_A_RST), 32'(CONST_B_RST), 32'(CONST_C_RST), 32'h0};
    foreach (a[i]) rd_chk("reset value", a[i], e[i]);
    wr(ADDR_RATIO, 32'h0000_1234);
    rd_chk("ratio read only", ADDR_RATIO, 32'h0000_0000);
    wr(ADDR_DELAY, 32'hffff_ffff);
    rd_chk("delay clamp", ADDR_DELAY, 32'(DELAY_MAX_MS));
    wr(ADDR_TMS, 32'h0000_0000);
    rd_chk("tms clamp", ADDR_TMS, 32'(TMS_MIN));
  endtask

  task automatic t_trip(input logic [2:0] c, input logic [31:0] d,
                        input logic [15:0] k, m, idle, input int ticks,
                        input logic [15:0] r);
    int n;
    wr(ADDR_CTRL, 32'(c));
    wr(ADDR_DELAY, d);
    wr(ADDR_TMS, 32'(k));
    @(posedge i_sys_clk);
    lvl <= m;
    wait_out(1'b0, 1'b1, n);
    wait_out(1'b1, 1'b1, n);
    check("trip ticks", (n + TICK / 2) / TICK, ticks);
    rd_chk("ratio", ADDR_RATIO, 32'(r));
    check("bus response", 32'(hresp), 32'h0000_0000);
    repeat (TICK) @(negedge i_sys_clk);
    check("trip held", trip, 1'b1);
    lvl <= idle;
    wait_out(1'b0, 1'b0, n);
    check("trip with start", trip, 1'b0);
  endtask

  task automatic t_hyst;
    int n;
    wr(ADDR_CTRL, 32'h0000_0000);
    lvl <= 16'h0200;
    wait_out(1'b0, 1'b1, n);
    lvl <= 16'h00f9;
    repeat (2 * TICK) @(negedge i_sys_clk);
    check("above reset level", start, 1'b1);
    lvl <= 16'h00f8;
    wait_out(1'b0, 1'b0, n);
    check("below reset level", start, 1'b0);
  endtask

  task automatic t_block;
    int n;
    logic [31:0] ts;
    wr(ADDR_DELAY, 32'h0000_03e8);
    lvl <= 16'h0200;
    wait_out(1'b0, 1'b1, n);
    blk_req <= 1'b1;
    n = 0;
    while (evt_v !== 1'b1 && n < 3 * TICK) begin
      @(negedge i_sys_clk);
      n++;
    end
    check("event", evt_v, 1'b1);
    // Stamp counts whole ticks since reset release
    ts = 32'(cyc / TICK);
    check("event time", evt_t, ts);
    check("start cleared", {start, trip}, 2'b00);
    check("inhibited", flag, 1'b1);
    check("event value", evt_m, 16'h0200);
    check("event type", evt_f, 1'b0);
    rd_chk("event time reg", ADDR_EVT_TIME, ts);
    rd_chk("event meas reg", ADDR_EVT_MEAS, 32'h0000_0200);
    rd_chk("status stage_inhibited_flag", ADDR_STATUS, 32'h0000_0009);
    repeat (2 * TICK) @(negedge i_sys_clk);
    check("still stage_inhibited_flag", start, 1'b0);
    blk_req <= 1'b0;
    wait_out(1'b0, 1'b1, n);
    check("resumed", start, 1'b1);
    lvl <= 16'h0000;
    wait_out(1'b0, 1'b0, n);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Budget: about 60 ticks of traffic, limit set well above
  initial begin
    #(TICK * 200 * 10);
    bad_count++;
    tally_and_finish;
  end

  // Inverse figures: IEC 5*860/1000=4; IEEE (14333+1850)/1000=16
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    t_regs;
    t_trip(3'h0, 0, 5, 16'h0200, 16'h0000, 0, 16'h0200);
    t_trip(3'h0, 3, 5, 16'h0200, 16'h0000, 3, 16'h0200);
    t_trip(3'h1, 0, 5, 16'h0080, 16'h0200, 0, 16'h0200);
    t_trip(3'h2, 0, 5, 16'h0200, 16'h0000, 4, 16'h0200);
    t_trip(3'h2, 10, 5, 16'h0200, 16'h0000, 10, 16'h0200);
    t_trip(3'h6, 0, 1, 16'h0400, 16'h0000, 16, 16'h0400);
    t_hyst;
    t_block;
    tally_and_finish;
  end
endmodule // tb
